// ===== edsd_pkg.sv
// Shared constants and types for the echo capture, streaming, sleep and isolation logic
package edsd_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Clock and time base
	localparam int CLK_NS         = 5;                                  // System clock period
	localparam int US_NS          = 1000;                               // One microsecond
	localparam int US_CYC         = (US_NS + CLK_NS - 1) / CLK_NS;      // Cycles per microsecond tick
	localparam int SLEEP_BASE_MS  = 250;                                // Idle timeout step
	localparam int SLEEP_BASE_CYC = SLEEP_BASE_MS * (US_NS * US_NS / CLK_NS); // Cycles per step
	localparam int ISOLATION_SWITCH_OUTPUT_STEP_US  = 16;                                 // Isolation timer step

	////////////////////////////////////////////////////////////////////////////////
	// Widths
	localparam int CMD_W      = 4;
	localparam int SAMPLE_W   = 12;
	localparam int TAP_N      = 4;
	localparam int TAP_W      = 3;
	localparam int REC_CODE_W = 4;
	localparam int REC_CNT_W  = 17;
	localparam int GRP_W      = 10;
	localparam int CAP_DEPTH  = 128;
	localparam int CAP_AW     = 7;
	localparam int US_W       = 8;
	localparam int DEC_W      = 13;
	localparam int SLEEP_W    = 32;

	////////////////////////////////////////////////////////////////////////////////
	// Record length: code n gives (n+1) base intervals
	localparam int REC_BASE_US = 4096;
	localparam int GRP_BASE    = REC_BASE_US / CAP_DEPTH;
	localparam logic [CAP_AW-1:0] CAP_LAST = 7'h7F;

	////////////////////////////////////////////////////////////////////////////////
	// Command codes
	localparam logic [CMD_W-1:0] CMD_BL_P1     = 4'h0;
	localparam logic [CMD_W-1:0] CMD_BL_P2     = 4'h1;
	localparam logic [CMD_W-1:0] CMD_LO_P1     = 4'h2;
	localparam logic [CMD_W-1:0] CMD_LO_P2     = 4'h3;
	localparam logic [CMD_W-1:0] CMD_SEND_RECV = 4'h4;
	localparam logic [CMD_W-1:0] CMD_RECV_ONLY = 4'h5;
	localparam logic [CMD_W-1:0] CMD_TEMP_READ = 4'h6;
	localparam logic [CMD_W-1:0] CMD_CAP_READ  = 4'h7;

	////////////////////////////////////////////////////////////////////////////////
	// Tap selector values and scaling knee
	localparam logic [TAP_W-1:0]    TAP_NONE  = 3'h0;
	localparam logic [TAP_W-1:0]    TAP_LPF   = 3'h1;
	localparam logic [TAP_W-1:0]    TAP_LIMIT = 3'h5;
	localparam logic [SAMPLE_W-1:0] NL_KNEE   = 12'h400;
	localparam logic [2:0]          LPF_TOP_SHIFT = 3'h4;

	////////////////////////////////////////////////////////////////////////////////
	// Stream sequencer states
	typedef enum logic [3:0] {
		EDSD_S_IDLE = 4'b0001,
		EDSD_S_DIAG = 4'b0010,
		EDSD_S_DATA = 4'b0100,
		EDSD_S_SUM  = 4'b1000
	} edsd_stream_e;

endpackage : edsd_pkg

// ===== edsd_sync.sv
// Three-stage pin synchroniser with agreement filter and falling-edge pulse
module edsd_sync (
	input  wire logic clk_in,     // System clock
	input  wire logic resetn_in,  // Async reset, active low
	input  wire logic pin_in,     // Asynchronous pin
	output logic      level_out,  // Filtered level
	output logic      fell_out    // One-cycle pulse on filtered falling edge
);
	import edsd_pkg::*;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
		logic fell;
	} edsd_sync_s;

	edsd_sync_s r;
	edsd_sync_s n;

	////////////////////////////////////////////////////////////////////////////////
	// Next state: chain, then accept a change once stages two and three agree
	always_comb begin
		n      = r;
		n.s1   = pin_in;
		n.s2   = r.s1;
		n.s3   = r.s2;
		n.fell = 1'b0;
		if ((r.s2 == r.s3) && (r.s3 != r.lvl)) begin
			n.lvl  = r.s3;
			n.fell = ~r.s3;
		end
	end

	// Registers; idle level of the lines is high
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			r <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, lvl: 1'b1, fell: 1'b0};
		end else begin
			r <= n;
		end
	end

	assign level_out = r.lvl;
	assign fell_out  = r.fell;

endmodule : edsd_sync

// ===== edsd_top.sv
// Echo capture store, raw sample streaming, idle sleep and isolation switch control
module edsd_top #(
	parameter int SLEEP_STEP_CYC = edsd_pkg::SLEEP_BASE_CYC  // Cycles per idle timeout step
) (
	input  wire logic                                          clk_in,                   // System clock
	input  wire logic                                          resetn_in,                // Async reset, low
	input  wire logic                                          link_clk_in,              // Master serial clock
	input  wire logic                                          cmd_valid_in,             // Command pulse
	input  wire logic [edsd_pkg::CMD_W-1:0]                    cmd_code_in,              // Command code
	input  wire logic                                          echo_capture_enable_in,   // Capture enable
	input  wire logic [edsd_pkg::REC_CODE_W-1:0]               preset1_record_length_in, // Preset 1 length
	input  wire logic [edsd_pkg::REC_CODE_W-1:0]               preset2_record_length_in, // Preset 2 length
	input  wire logic                                          active_preset_in,         // Preset for streams
	input  wire logic [7:0]                                    capture_sample_in,        // Path output byte
	input  wire logic                                          sample_strobe_in,         // 1 us sample pulse
	input  wire logic [edsd_pkg::TAP_N*edsd_pkg::SAMPLE_W-1:0] tap_bus_in,               // Taps 1..4
	input  wire logic [edsd_pkg::TAP_W-1:0]                    datapath_tap_select_in,   // Tap selector
	input  wire logic                                          sync_mode_in,             // Synchronous mode
	input  wire logic                                          sample_width_select_in,   // 0: 8 bit, 1: 12 bit
	input  wire logic [1:0]                                    gain_select_in,           // Digital gain select
	input  wire logic [7:0]                                    diag_in,                  // Diagnostic byte
	input  wire logic                                          sleep_enable_in,          // Sleep enable
	input  wire logic [1:0]                                    sleep_idle_timeout_in,    // Idle timeout field
	input  wire logic                                          eeprom_busy_in,           // EEPROM programming
	input  wire logic                                          io_in,                    // One-wire line level
	input  wire logic                                          rxd_in,                   // Serial receive pin
	input  wire logic                                          burst_active_in,          // Burst stage
	input  wire logic                                          isolation_source_select_in, // 0 time, 1 temp
	input  wire logic [7:0]                                    isolation_setpoint_in,    // Setpoint
	input  wire logic [7:0]                                    temp_in,                  // Temperature result
	input  wire logic                                          temp_valid_in,            // Result pulse
	output logic                                               io_out_out,               // Line drive value
	output logic                                               io_oe_out,                // Line drive enable
	output logic [7:0]                                         dump_data_out,            // Capture read byte
	output logic                                               dump_valid_out,           // Read byte valid
	output logic                                               capture_done_out,         // Capture ready
	output logic                                               txd_out,                  // Serial data out
	output logic                                               stream_active_out,        // Frame in progress
	output logic                                               detect_disable_out,       // Detection off
	output logic                                               low_power_out,            // Low-power mode
	output logic                                               isolation_switch_output_out, // Switch gate
	output logic                                               temp_req_out              // Measure request
);
	import edsd_pkg::*;

	localparam logic [US_W-1:0] US_LAST = US_W'(US_CYC - 1);

	////////////////////////////////////////////////////////////////////////////////
	// State of the system domain
	typedef struct packed {
		logic [CAP_DEPTH-1:0][7:0] mem;
		logic                      rec_act;
		logic                      cap_act;
		logic                      cap_done;
		logic                      io_low;
		logic                      io_lvl;
		logic [REC_CNT_W-1:0]      rec_cnt;
		logic [REC_CNT_W-1:0]      rec_len;
		logic [GRP_W-1:0]          grp_cnt;
		logic [GRP_W-1:0]          grp_size;
		logic [CAP_AW-1:0]         addr;
		logic [7:0]                peak;
		logic                      rd_act;
		logic [CAP_AW-1:0]         rd_addr;
		logic                      dump_valid;
		logic [7:0]                dump_data;
		edsd_stream_e              st;
		logic [REC_CNT_W-1:0]      s_cnt;
		logic [REC_CNT_W-1:0]      s_len;
		logic                      half;
		logic [3:0]                roll;
		logic [7:0]                q0;
		logic [7:0]                q1;
		logic [1:0]                qn;
		logic [7:0]                sum;
		logic [7:0]                tx_byte;
		logic                      req_t;
		logic                      ack_s1;
		logic                      ack_s2;
		logic                      detect_dis;
		logic [SLEEP_W-1:0]        sleep_cnt;
		logic                      low_power;
		logic [US_W-1:0]           us_cnt;
		logic [DEC_W-1:0]          dec_cnt;
		logic                      dec_armed;
		logic                      dec_timing;
		logic                      isolation_switch_output;
		logic                      temp_wait;
		logic                      temp_req;
		logic                      burst_prev;
	} edsd_sys_s;

	// State of the link domain
	typedef struct packed {
		logic       req_s1;
		logic       req_s2;
		logic       ack_t;
		logic [7:0] sh;
		logic [3:0] bits;
		logic       txd;
	} edsd_link_s;

	edsd_sys_s  r;
	edsd_sys_s  n;
	edsd_link_s lr;
	edsd_link_s ln;

	logic                 io_fell;
	logic                 rxd_fell;
	logic                 tick;
	logic                 is_run;
	logic                 run_lo;
	logic                 stream_ok;
	logic                 free;
	logic                 send_en;
	logic [7:0]           send_byte;
	logic [7:0]           pk;
	logic [REC_CODE_W-1:0] code;
	logic [REC_CODE_W-1:0] s_code;
	logic [SAMPLE_W-1:0]  tap;
	logic [SAMPLE_W-1:0]  scaled;
	logic [7:0]           b8;
	logic [SLEEP_W-1:0]   period;
	logic [DEC_W-1:0]     dec_limit;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers for wake-up
	edsd_sync u_io_sync (
		.clk_in    (clk_in),
		.resetn_in (resetn_in),
		.pin_in    (io_in),
		.level_out (),
		.fell_out  (io_fell)
	);

	edsd_sync u_rxd_sync (
		.clk_in    (clk_in),
		.resetn_in (resetn_in),
		.pin_in    (rxd_in),
		.level_out (),
		.fell_out  (rxd_fell)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Knee compression on the low-pass tap
	function automatic logic [SAMPLE_W-1:0] nl_scale(input logic [SAMPLE_W-1:0] s);
		logic [SAMPLE_W-1:0] over;
		over = s - NL_KNEE;
		if (s > NL_KNEE) begin
			nl_scale = NL_KNEE + (over >> 1);
		end else begin
			nl_scale = s;
		end
	endfunction : nl_scale

	// Byte picked from a 12-bit sample in 8-bit mode
	function automatic logic [7:0] pick8(input logic [SAMPLE_W-1:0] s, input logic lpf, input logic [1:0] g);
		logic [SAMPLE_W-1:0] sh;
		sh = s >> (LPF_TOP_SHIFT - {1'b0, g});
		if (lpf) begin
			pick8 = sh[7:0];
		end else if (g == 2'h0) begin
			pick8 = s[11:4];
		end else begin
			pick8 = s[7:0];
		end
	endfunction : pick8

	////////////////////////////////////////////////////////////////////////////////
	// Command decode and derived values
	always_comb begin
		is_run    = cmd_valid_in && ((cmd_code_in == CMD_BL_P1) || (cmd_code_in == CMD_BL_P2) ||
		            (cmd_code_in == CMD_LO_P1) || (cmd_code_in == CMD_LO_P2));
		run_lo    = (cmd_code_in == CMD_LO_P1) || (cmd_code_in == CMD_LO_P2);
		code      = ((cmd_code_in == CMD_BL_P2) || (cmd_code_in == CMD_LO_P2)) ?
		            preset2_record_length_in : preset1_record_length_in;
		s_code    = active_preset_in ? preset2_record_length_in : preset1_record_length_in;
		stream_ok = (datapath_tap_select_in > TAP_NONE) && (datapath_tap_select_in < TAP_LIMIT) &&
		            sync_mode_in;
		tap       = TAP_NONE;
		for (int i = 0; i < TAP_N; i++) begin
			if (datapath_tap_select_in == TAP_W'(i + 1)) begin
				tap = tap_bus_in[i*SAMPLE_W +: SAMPLE_W];
			end
		end
		scaled    = (datapath_tap_select_in == TAP_LPF) ? nl_scale(tap) : tap;
		b8        = pick8(scaled, datapath_tap_select_in == TAP_LPF, gain_select_in);
		pk        = ((r.grp_cnt == '0) || (capture_sample_in > r.peak)) ? capture_sample_in : r.peak;
		free      = (r.ack_s2 == r.req_t);
		tick      = (r.us_cnt == US_LAST);
		period    = SLEEP_W'((32'(sleep_idle_timeout_in) + 32'h1) * 32'(SLEEP_STEP_CYC));
		dec_limit = DEC_W'(32'(isolation_setpoint_in) * ISOLATION_SWITCH_OUTPUT_STEP_US);
	end

	////////////////////////////////////////////////////////////////////////////////
	// System domain next state
	always_comb begin
		n            = r;
		send_en      = 1'b0;
		send_byte    = 8'h00;
		n.dump_valid = 1'b0;
		n.temp_req   = 1'b0;
		n.ack_s1     = lr.ack_t;
		n.ack_s2     = r.ack_s1;
		n.burst_prev = burst_active_in;
		n.us_cnt     = tick ? '0 : r.us_cnt + 1'b1;

		// Record interval and down-sampled peak capture
		if (is_run && !r.rec_act) begin
			n.rec_act  = 1'b1;
			n.rec_cnt  = '0;
			n.rec_len  = REC_CNT_W'((32'(code) + 32'h1) * REC_BASE_US);
			n.grp_size = GRP_W'((32'(code) + 32'h1) * GRP_BASE);
			n.grp_cnt  = '0;
			n.addr     = '0;
			n.cap_act  = echo_capture_enable_in;
			n.io_low   = echo_capture_enable_in;
			if (echo_capture_enable_in) begin
				n.cap_done = 1'b0;
			end
		end else if (r.rec_act && sample_strobe_in) begin
			n.rec_cnt = r.rec_cnt + 1'b1;
			if (r.cap_act) begin
				n.peak = pk;
				if (r.grp_cnt == r.grp_size - 1'b1) begin
					n.mem[r.addr] = pk;
					n.addr        = r.addr + 1'b1;
					n.grp_cnt     = '0;
				end else begin
					n.grp_cnt = r.grp_cnt + 1'b1;
				end
			end
			if (r.rec_cnt == r.rec_len - 1'b1) begin
				n.rec_act  = 1'b0;
				n.cap_act  = 1'b0;
				n.io_low   = 1'b0;
				n.cap_done = r.cap_done | r.cap_act;
			end
		end
		n.io_lvl = ~n.io_low;

		// Capture read: one stored byte per cycle
		if (cmd_valid_in && (cmd_code_in == CMD_CAP_READ) && r.cap_done && !r.rd_act) begin
			n.rd_act  = 1'b1;
			n.rd_addr = '0;
		end else if (r.rd_act) begin
			n.dump_valid = 1'b1;
			n.dump_data  = r.mem[r.rd_addr];
			n.rd_addr    = r.rd_addr + 1'b1;
			if (r.rd_addr == CAP_LAST) begin
				n.rd_act = 1'b0;
			end
		end

		// Stream frame sequencer
		case (r.st)
			EDSD_S_IDLE: begin
				if (cmd_valid_in && stream_ok && free && ((cmd_code_in == CMD_SEND_RECV) ||
				    (cmd_code_in == CMD_RECV_ONLY) || (cmd_code_in == CMD_TEMP_READ))) begin
					n.st    = EDSD_S_DIAG;
					n.sum   = 8'h00;
					n.s_cnt = '0;
					n.s_len = REC_CNT_W'((32'(s_code) + 32'h1) * REC_BASE_US);
					n.half  = 1'b0;
					n.roll  = 4'h0;
					n.qn    = 2'h0;
				end
			end
			EDSD_S_DIAG: begin
				if (free) begin
					send_en   = 1'b1;
					send_byte = diag_in;
					n.st      = EDSD_S_DATA;
				end
			end
			EDSD_S_DATA: begin
				if (r.qn != 2'h0) begin
					if (free) begin
						send_en   = 1'b1;
						send_byte = r.q0;
						n.q0      = r.q1;
						n.qn      = r.qn - 1'b1;
					end
				end else if (sample_strobe_in && (r.s_cnt != r.s_len)) begin
					n.s_cnt = r.s_cnt + 1'b1;
					n.half  = ~r.half;
					if (!sample_width_select_in) begin
						n.q0 = b8;
						n.qn = 2'h1;
					end else if (!r.half) begin
						n.q0   = scaled[7:0];
						n.q1   = {r.roll, scaled[11:8]};
						n.qn   = 2'h2;
						n.roll = r.roll + 1'b1;
					end
				end else if ((r.s_cnt == r.s_len) && free) begin
					n.st = EDSD_S_SUM;
				end
			end
			EDSD_S_SUM: begin
				if (free) begin
					send_en   = 1'b1;
					send_byte = ~r.sum;
					n.st      = EDSD_S_IDLE;
				end
			end
			default: begin
				n.st = EDSD_S_IDLE;
			end
		endcase

		// Hand a byte to the link domain by request toggle
		if (send_en) begin
			n.tx_byte = send_byte;
			n.req_t   = ~r.req_t;
			n.sum     = r.sum + send_byte;
		end
		n.detect_dis = echo_capture_enable_in | (n.st != EDSD_S_IDLE);

		// Inactivity timer and wake-up
		if (!sleep_enable_in) begin
			n.sleep_cnt = '0;
			n.low_power = 1'b0;
		end else if (r.low_power) begin
			if (io_fell || rxd_fell) begin
				n.low_power = 1'b0;
				n.sleep_cnt = '0;
			end
		end else if (cmd_valid_in || eeprom_busy_in) begin
			n.sleep_cnt = '0;
		end else if (r.sleep_cnt >= period - 1'b1) begin
			n.low_power = 1'b1;
			n.sleep_cnt = '0;
		end else begin
			n.sleep_cnt = r.sleep_cnt + 1'b1;
		end

		// Isolation switch: time mode and temperature mode
		if (is_run && !r.rec_act) begin
			if (!isolation_source_select_in) begin
				n.isolation_switch_output      = 1'b1;
				n.dec_cnt    = '0;
				n.dec_armed  = ~run_lo;
				n.dec_timing = run_lo;
				n.temp_wait  = 1'b0;
			end else begin
				n.temp_req   = 1'b1;
				n.temp_wait  = 1'b1;
				n.dec_armed  = 1'b0;
				n.dec_timing = 1'b0;
			end
		end else begin
			if (r.dec_armed && r.burst_prev && !burst_active_in) begin
				n.dec_armed  = 1'b0;
				n.dec_timing = 1'b1;
			end
			if (r.dec_timing && tick) begin
				if (r.dec_cnt >= dec_limit) begin
					n.isolation_switch_output      = 1'b0;
					n.dec_timing = 1'b0;
				end else begin
					n.dec_cnt = r.dec_cnt + 1'b1;
				end
			end
			if (r.temp_wait && temp_valid_in) begin
				n.isolation_switch_output     = ~(temp_in > isolation_setpoint_in);
				n.temp_wait = 1'b0;
			end
		end
	end

	// System domain registers
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			r        <= '0;
			r.st     <= EDSD_S_IDLE;
			r.io_lvl <= 1'b1;
		end else begin
			r <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Link domain: take handed bytes and shift them out LSB first, back to back
	always_comb begin
		ln        = lr;
		ln.req_s1 = r.req_t;
		ln.req_s2 = lr.req_s1;
		if ((lr.bits == 4'h0) && (lr.req_s2 != lr.ack_t)) begin
			ln.txd   = r.tx_byte[0];
			ln.sh    = r.tx_byte >> 1;
			ln.bits  = 4'h7;
			ln.ack_t = lr.req_s2;
		end else if (lr.bits != 4'h0) begin
			ln.txd  = lr.sh[0];
			ln.sh   = lr.sh >> 1;
			ln.bits = lr.bits - 1'b1;
		end else begin
			ln.txd = 1'b1;
		end
	end

	// Link domain registers
	always_ff @(posedge link_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			lr     <= '0;
			lr.txd <= 1'b1;
		end else begin
			lr <= ln;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign io_out_out                  = r.io_lvl;
	assign io_oe_out                   = r.io_low;
	assign dump_data_out               = r.dump_data;
	assign dump_valid_out              = r.dump_valid;
	assign capture_done_out            = r.cap_done;
	assign txd_out                     = lr.txd;
	assign stream_active_out           = ~r.st[0];
	assign detect_disable_out          = r.detect_dis;
	assign low_power_out               = r.low_power;
	assign isolation_switch_output_out = r.isolation_switch_output;
	assign temp_req_out                = r.temp_req;

endmodule : edsd_top

// ===== edsd_sva.sv
// Concurrent checks on edsd_top ports
module edsd_sva (
	input wire logic       clk_in, resetn_in, cmd_valid_in, echo_capture_enable_in, io_oe_out, io_out_out,
	input wire logic [3:0] cmd_code_in,
	input wire logic       capture_done_out, detect_disable_out, dump_valid_out, isolation_source_select_in,
	input wire logic       temp_valid_in, isolation_switch_output_out, low_power_out, eeprom_busy_in, sleep_enable_in,
	input wire logic [7:0] temp_in, isolation_setpoint_in
);
	// System clock, idle in reset
	default clocking @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	a_line_low: assert property (io_oe_out |-> !io_out_out) else $error("line not low");
	a_rec_start: assert property (cmd_valid_in && cmd_code_in < 4'h4 && echo_capture_enable_in
		&& !io_oe_out |=> io_oe_out) else $error("no capture hold");
	a_rec_end: assert property ($rose(capture_done_out) |-> $fell(io_oe_out)) else $error("hold end");
	a_detect_off: assert property (echo_capture_enable_in [*2] |-> detect_disable_out) else $error("detect");
	a_dump_ready: assert property ($rose(dump_valid_out) |-> capture_done_out) else $error("early read");
	a_temp_low: assert property (isolation_source_select_in && temp_valid_in && temp_in <= isolation_setpoint_in
		|=> isolation_switch_output_out) else $error("switch low");
	a_temp_high: assert property (isolation_source_select_in && temp_valid_in && temp_in > isolation_setpoint_in
		|=> !isolation_switch_output_out) else $error("switch high");
	a_cmd_awake: assert property (cmd_valid_in && !low_power_out |=> !low_power_out) else $error("slept");
	a_ee_hold: assert property (eeprom_busy_in [*2] |-> !$rose(low_power_out)) else $error("ee sleep");
	a_sleep_off: assert property (!sleep_enable_in [*2] |-> !$rose(low_power_out)) else $error("sleep");
endmodule : edsd_sva

bind edsd_top edsd_sva edsd_sva_inst (.*);

// ===== edsd_host.sv
// Host model: gated serial clock and byte collector
module edsd_host (
	input  wire logic go_in,       // Clock enable
	input  wire logic txd_in,      // Device data
	output logic      link_clk_out // Serial clock
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] sh = 8'h00;
	logic [7:0] q[$];
	int         nb = 0;
	// Clock stands low while go_in is low
	initial begin
		link_clk_out = 1'h0;
		#7;
		forever #24 link_clk_out = go_in & ~link_clk_out;
	end
	// First low bit opens the frame, LSB first
	always @(negedge link_clk_out) begin
		if (nb > 0 || !txd_in) begin
			sh = {txd_in, sh[7:1]};
			nb++;
			if (nb % 8 == 0)
				q.push_back(sh);
		end
	end
endmodule : edsd_host

// ===== testbench.sv
// Self-checking bench for edsd_top
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in = 1'h0, resetn_in = 1'h0, cmd_valid_in = 1'h0, echo_capture_enable_in = 1'h1, go = 1'h0;
	logic sample_strobe_in = 1'h0, sync_mode_in = 1'h0, sample_width_select_in = 1'h0, sleep_enable_in = 1'h0;
	logic eeprom_busy_in = 1'h0, rxd_in = 1'h1, burst_active_in = 1'h0, isolation_source_select_in = 1'h0;
	logic temp_valid_in = 1'h0, io_host = 1'h1, active_preset_in = 1'h0, link_clk_in;
	logic [3:0] cmd_code_in = 4'h0, preset1_record_length_in = 4'h0, preset2_record_length_in = 4'h0;
	logic [47:0] tap_bus_in = 48'h0;
	logic [7:0] capture_sample_in = 8'h00, diag_in = 8'h5A, isolation_setpoint_in = 8'h40, temp_in = 8'h00;
	logic [7:0] v, dump_data_out, exp_peak[128];
	logic [2:0] datapath_tap_select_in = 3'h0;
	logic [1:0] gain_select_in = 2'h0, sleep_idle_timeout_in = 2'h1;
	logic io_out_out, io_oe_out, dump_valid_out, capture_done_out, txd_out, stream_active_out, temp_req_out;
	logic detect_disable_out, low_power_out, isolation_switch_output_out;
	wire io_in = io_oe_out ? 1'h0 : io_host;
	int mismatches = 0, compares = 0, cyc = 0;
	edsd_top #(.SLEEP_STEP_CYC(100)) edsd_top_inst (.*);
	edsd_host edsd_host_inst (.go_in(go), .txd_in(txd_out), .link_clk_out(link_clk_in));
	////////////////////////////////////////
	// Clock and hang ceiling
	always #2.5 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 80000) begin
			mismatches++;
			close_out();
		end
	end
	// Verdict
	task close_out;
		if (mismatches == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out
	// Byte and flag compares
	task chk(input logic [7:0] got, input logic [7:0] want);
		compares++;
		if (got !== want) begin
			mismatches++;
			$display("BAD %0t got %h want %h", $time, got, want);
		end
	endtask : chk
	task chkb(input logic got, input logic want);
		chk({7'h00, got}, {7'h00, want});
	endtask : chkb
	// Edge waits and one-cycle pulses
	task tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : tick
	task cmd(input logic [3:0] c);
		@(posedge clk_in);
		cmd_valid_in <= 1'h1;
		cmd_code_in <= c;
		@(posedge clk_in);
		cmd_valid_in <= 1'h0;
		#1;
	endtask : cmd
	task strobe(input logic [7:0] s);
		@(posedge clk_in);
		sample_strobe_in <= 1'h1;
		capture_sample_in <= s;
		@(posedge clk_in);
		sample_strobe_in <= 1'h0;
	endtask : strobe
	// Record 4096 samples, read back group peaks
	task t_capture;
		cmd(4'h0);
		chkb(io_oe_out, 1'h1);
		for (int i = 0; i < 4096; i++) begin
			v = 8'(i * 37);
			if (i % 32 == 0 || v > exp_peak[i / 32])
				exp_peak[i / 32] = v;
			strobe(v);
		end
		tick(3);
		chkb(capture_done_out, 1'h1);
		chkb(io_oe_out, 1'h0);
		cmd(4'h7);
		for (int k = 0; k < 8 && dump_valid_out !== 1'h1; k++)
			tick(1);
		for (int j = 0; j < 128; j++) begin
			chk(dump_data_out, exp_peak[j]);
			tick(1);
		end
	endtask : t_capture
	// Refused tap, then low-pass stream
	task t_stream;
		@(posedge clk_in);
		echo_capture_enable_in <= 1'h0;
		sync_mode_in <= 1'h1;
		datapath_tap_select_in <= 3'h5;
		tap_bus_in <= 48'hC00;
		go <= 1'h1;
		cmd(4'h4);
		tick(4);
		chkb(stream_active_out, 1'h0);
		@(posedge clk_in);
		datapath_tap_select_in <= 3'h1;
		cmd(4'h5);
		tick(4);
		chkb(detect_disable_out, 1'h1);
		repeat (6) begin
			strobe(8'h00);
			tick(110);
		end
		chk(edsd_host_inst.q[0], diag_in);
		chk(edsd_host_inst.q[1], 8'h80);
	endtask : t_stream
	// Temperature result against setpoint
	task tv(input logic [7:0] t, input logic want);
		@(posedge clk_in);
		temp_valid_in <= 1'h1; // no other command while converting
		temp_in <= t;
		@(posedge clk_in);
		temp_valid_in <= 1'h0;
		tick(1);
		chkb(isolation_switch_output_out, want);
	endtask : tv
	// Reset in mid-run, then a temperature-mode run
	task rst_run;
		@(posedge clk_in);
		resetn_in <= 1'h0;
		go <= 1'h0;
		isolation_source_select_in <= 1'h1;
		tick(4);
		@(posedge clk_in);
		resetn_in <= 1'h1;
		cmd(4'h1);
		chkb(temp_req_out, 1'h1);
	endtask : rst_run
	// Idle sleep, EEPROM hold, wake on line
	task t_sleep;
		@(posedge clk_in);
		sleep_enable_in <= 1'h1;
		tick(150);
		cmd(4'h7);
		tick(150);
		chkb(low_power_out, 1'h0);
		@(posedge clk_in);
		eeprom_busy_in <= 1'h1;
		tick(300);
		@(posedge clk_in);
		eeprom_busy_in <= 1'h0;
		tick(185);
		chkb(low_power_out, 1'h0);
		tick(30);
		chkb(low_power_out, 1'h1);
		@(posedge clk_in);
		io_host <= 1'h0;
		rxd_in <= 1'h0;
		tick(10);
		chkb(low_power_out, 1'h0);
		tick(60000);
		@(posedge clk_in);
		io_host <= 1'h1;
		rxd_in <= 1'h1;
		tick(10);
	endtask : t_sleep
	////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (20) @(posedge clk_in);
		resetn_in <= 1'h1;
		tick(4);
		t_capture();
		t_stream();
		rst_run();
		tv(8'h40, 1'h1);
		rst_run();
		tv(8'h41, 1'h0);
		t_sleep();
		close_out();
	end
endmodule : testbench
